// ---- core/udc_pkg.sv ----
// Package of the up/down threshold counter: register map, field
// positions, reset values and limits shared by design and bench.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package udc_pkg;
    // ==================================================================
    // Register byte offsets.
    // ==================================================================
    localparam logic [7:0] UDC_OFF_CONFIG = 8'h00; // Options.
    localparam logic [7:0] UDC_OFF_INIT   = 8'h04; // Initial value.
    localparam logic [7:0] UDC_OFF_UPPER  = 8'h08; // Upper limit.
    localparam logic [7:0] UDC_OFF_LOWER  = 8'h0C; // Lower limit.
    localparam logic [7:0] UDC_OFF_COUNT  = 8'h10; // Actual count, RO.
    localparam logic [7:0] UDC_OFF_STATUS = 8'h14; // Flags, RO.

    // ==================================================================
    // Field positions.
    // ==================================================================
    localparam int UDC_CFG_ENREQ_BIT  = 0;  // Enable input required.
    localparam int UDC_CFG_RETAIN_LSB = 8;  // Retentive instance count.
    localparam int UDC_ST_UPPER_BIT   = 0;  // At or above upper.
    localparam int UDC_ST_LOWER_BIT   = 1;  // At or below lower.
    localparam int UDC_ST_NULL_BIT    = 2;  // Count is zero.
    localparam int UDC_ST_CARRY_BIT   = 3;  // Range carry pulse.

    // ==================================================================
    // Reset values and constants.
    // ==================================================================
    localparam logic [31:0] UDC_RST_CONFIG = 32'h0000_0000;
    localparam logic [31:0] UDC_RST_INIT   = 32'h0000_0000;
    localparam logic [31:0] UDC_RST_UPPER  = 32'h0000_0064;
    localparam logic [31:0] UDC_RST_LOWER  = 32'h0000_0000;
    localparam logic [7:0]  UDC_INST_INDEX = 8'h00; // This instance.
    localparam int          UDC_NV_BYTES   = 4;     // Retained bytes.
    localparam logic [1:0]  UDC_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  UDC_RESP_SLV   = 2'h2;

    // Excursion state held after leaving the signed range.
    typedef enum logic [1:0] {UDC_EX_NONE, UDC_EX_POS, UDC_EX_NEG}
        udc_exc_t;
endpackage

// ---- core/udc_counter.sv ----
// Up/down threshold counter with an AXI4-Lite register slave.
// Assumes count, direction, load, clear, enable and run inputs are
// synchronous to ref_clk and driven by the program scan logic.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns

// How it works
// - Optionally act only while enable is high
// - Zero count sets null flag, and below-lower flag only while lower limit >= 0
// - Direction low: each pulse increments count
// - Counting past lower limit drops below-lower flag
// - Above-upper flag when count >= upper limit
// - Below-lower flag when count <= lower limit
// - Load edge copies initial value, flags follow
// - Direction high: each pulse decrements count
// - Clear forces count zero, null flag set
// - Carry flags counts leaving signed range
// - Excursion sets flags by its direction
// - Config selects how many instances retain
// - Retained count uses four bytes storage
// - Retained count survives stop and power loss
// - Run start resumes from stored count
// - Only rising count edges are counted
// - Carry one cycle, count keeps last value
// - Count is signed 32-bit two's complement
module udc_counter (
    input  wire  logic        ref_clk,
    input  wire  logic        resetn,
    input  wire  logic        countPulse,
    input  wire  logic        countDown,
    input  wire  logic        loadInitial,
    input  wire  logic        clearInput,
    input  wire  logic        enableIn,
    input  wire  logic        runMode,
    output logic              actualCountValid,
    output logic [31:0]       actualCount,
    output logic              atOrAboveUpper,
    output logic              atOrBelowLower,
    output logic              countIsNull,
    output logic              rangeCarry,
    input  wire  logic        s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire  logic [7:0]  s_axi_awaddr,
    input  wire  logic        s_axi_wvalid,
    output logic              s_axi_wready,
    input  wire  logic [31:0] s_axi_wdata,
    input  wire  logic [3:0]  s_axi_wstrb,
    output logic              s_axi_bvalid,
    input  wire  logic        s_axi_bready,
    output logic [1:0]        s_axi_bresp,
    input  wire  logic        s_axi_arvalid,
    output logic              s_axi_arready,
    input  wire  logic [7:0]  s_axi_araddr,
    output logic              s_axi_rvalid,
    input  wire  logic        s_axi_rready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp
);
    import udc_pkg::*;

    // ==================================================================
    // State.
    // ==================================================================
    // All clocked state of the block except the retained storage in one record.
    typedef struct packed {
        logic [31:0] cfg;      // Options register.
        logic [31:0] init;     // Initial value.
        logic [31:0] upper;    // Upper limit value.
        logic [31:0] lower;    // Lower limit value.
        logic [31:0] count;    // Actual count.
        logic        fUp;      // At or above upper.
        logic        fLo;      // At or below lower.
        logic        fNull;    // Count is null.
        logic        carry;    // Range carry pulse.
        udc_exc_t    exc;      // Excursion state.
        logic        pPrev;    // Last count pulse level.
        logic        lPrev;    // Last load level.
        logic        rPrev;    // Last run level.
        logic        awHeld;   // Write address taken.
        logic [7:0]  awAddr;   // Held write address.
        logic        wHeld;    // Write data taken.
        logic [31:0] wData;    // Held write data.
        logic [3:0]  wStrb;    // Held byte enables.
        logic        awRdy;    // Write address ready.
        logic        wRdy;     // Write data ready.
        logic        bVal;     // Write response valid.
        logic [1:0]  bResp;    // Write response code.
        logic        arRdy;    // Read address ready.
        logic        rVal;     // Read data valid.
        logic [31:0] rData;    // Read data.
        logic [1:0]  rResp;    // Read response code.
    } udc_state_t;

    udc_state_t st_ff;   // Registered state.
    udc_state_t nxt_st;  // Next state.

    // Retained count bytes; no reset so they survive a reset.
    logic [7:0] nvMem [UDC_NV_BYTES];
    logic       retain;  // This instance is retentive.
    logic       active;  // Counter may act this cycle.
    logic       rise;    // Rising count edge.
    logic       nvOk;    // Storage has been written since power-up.

    assign retain = UDC_INST_INDEX < st_ff.cfg[UDC_CFG_RETAIN_LSB +: 8];
    assign active = ~st_ff.cfg[UDC_CFG_ENREQ_BIT] | enableIn;
    assign rise   = countPulse & ~st_ff.pPrev;

    // Merges a write word into a register under byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (stb[i]) begin
                r[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ==================================================================
    // Next-state logic.
    // ==================================================================
    // Bus slave first, then counter, then flags from the new values.
    always_comb begin
        logic [32:0] sum;   // Widened count step.
        logic        ovf;   // Step leaves the signed range.
        logic        wrOk;  // Write address is mapped.
        nxt_st = st_ff;
        sum    = 33'h0_0000_0000;
        ovf    = 1'b0;
        wrOk   = 1'b0;
        // Responses retire when the master accepts them.
        if (st_ff.bVal && s_axi_bready) begin
            nxt_st.bVal = 1'b0;
        end
        if (st_ff.rVal && s_axi_rready) begin
            nxt_st.rVal = 1'b0;
        end
        // Address and data are taken independently, in either order.
        if (s_axi_awvalid && st_ff.awRdy) begin
            nxt_st.awHeld = 1'b1;
            nxt_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wRdy) begin
            nxt_st.wHeld = 1'b1;
            nxt_st.wData = s_axi_wdata;
            nxt_st.wStrb = s_axi_wstrb;
        end
        // Both halves held and no response pending: do the write.
        if (st_ff.awHeld && st_ff.wHeld && !st_ff.bVal) begin
            wrOk = 1'b1;
            unique case (st_ff.awAddr)
                UDC_OFF_CONFIG: nxt_st.cfg =
                    merge(st_ff.cfg, st_ff.wData, st_ff.wStrb);
                UDC_OFF_INIT: nxt_st.init =
                    merge(st_ff.init, st_ff.wData, st_ff.wStrb);
                UDC_OFF_UPPER: nxt_st.upper =
                    merge(st_ff.upper, st_ff.wData, st_ff.wStrb);
                UDC_OFF_LOWER: nxt_st.lower =
                    merge(st_ff.lower, st_ff.wData, st_ff.wStrb);
                UDC_OFF_COUNT, UDC_OFF_STATUS: wrOk = 1'b1;
                default: wrOk = 1'b0;
            endcase
            nxt_st.bVal   = 1'b1;
            nxt_st.bResp  = wrOk ? UDC_RESP_OKAY : UDC_RESP_SLV;
            nxt_st.awHeld = 1'b0;
            nxt_st.wHeld  = 1'b0;
        end
        nxt_st.awRdy = ~nxt_st.awHeld & ~nxt_st.bVal;
        nxt_st.wRdy  = ~nxt_st.wHeld & ~nxt_st.bVal;
        // Reads answer on the same edge that takes the address.
        if (s_axi_arvalid && st_ff.arRdy) begin
            nxt_st.rVal  = 1'b1;
            nxt_st.rResp = UDC_RESP_OKAY;
            unique case (s_axi_araddr)
                UDC_OFF_CONFIG: nxt_st.rData = st_ff.cfg;
                UDC_OFF_INIT:   nxt_st.rData = st_ff.init;
                UDC_OFF_UPPER:  nxt_st.rData = st_ff.upper;
                UDC_OFF_LOWER:  nxt_st.rData = st_ff.lower;
                UDC_OFF_COUNT:  nxt_st.rData = st_ff.count;
                UDC_OFF_STATUS: nxt_st.rData = {28'h000_0000,
                    st_ff.carry, st_ff.fNull, st_ff.fLo, st_ff.fUp};
                default: begin
                    nxt_st.rData = 32'h0000_0000;
                    nxt_st.rResp = UDC_RESP_SLV;
                end
            endcase
        end
        nxt_st.arRdy = ~nxt_st.rVal;

        // Counter: edges are tracked every cycle.
        nxt_st.pPrev = countPulse;
        nxt_st.lPrev = loadInitial;
        nxt_st.rPrev = runMode;
        nxt_st.carry = 1'b0;
        if (runMode && !st_ff.rPrev) begin
            // Run start: resume retained count if stored, zero if not retentive, else keep the count.
            if (retain && nvOk) begin
                nxt_st.count = {nvMem[3], nvMem[2],
                                nvMem[1], nvMem[0]};
            end else if (!retain) begin
                nxt_st.count = 32'h0000_0000;
            end
            nxt_st.exc = UDC_EX_NONE;
        end else if (runMode && active) begin
            if (clearInput) begin
                nxt_st.count = 32'h0000_0000;
                nxt_st.exc   = UDC_EX_NONE;
            end else if (loadInitial && !st_ff.lPrev) begin
                nxt_st.count = st_ff.init;
                nxt_st.exc   = UDC_EX_NONE;
            end else if (rise) begin
                // Signed step in 33 bits to see the range edge.
                sum = countDown
                    ? {st_ff.count[31], st_ff.count} - 33'h0_0000_0001
                    : {st_ff.count[31], st_ff.count} + 33'h0_0000_0001;
                ovf = sum[32] ^ sum[31];
                if (ovf) begin
                    nxt_st.carry = 1'b1;
                    nxt_st.exc = countDown ? UDC_EX_NEG : UDC_EX_POS;
                end else begin
                    nxt_st.count = sum[31:0];
                    nxt_st.exc   = UDC_EX_NONE;
                end
            end
        end
        // Flags from the new count and new limits.
        unique case (nxt_st.exc)
            UDC_EX_POS: begin
                nxt_st.fUp   = 1'b1;
                nxt_st.fLo   = 1'b0;
                nxt_st.fNull = 1'b0;
            end
            UDC_EX_NEG: begin
                nxt_st.fUp   = 1'b0;
                nxt_st.fLo   = 1'b1;
                nxt_st.fNull = 1'b0;
            end
            default: begin
                nxt_st.fUp = $signed(nxt_st.count)
                          >= $signed(nxt_st.upper);
                nxt_st.fLo = $signed(nxt_st.count)
                          <= $signed(nxt_st.lower);
                nxt_st.fNull = nxt_st.count == 32'h0000_0000;
            end
        endcase
    end

    // ==================================================================
    // Registers.
    // ==================================================================
    // Registers the whole state; reset gives every field a constant.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff        <= '0;
            st_ff.cfg    <= UDC_RST_CONFIG;
            st_ff.init   <= UDC_RST_INIT;
            st_ff.upper  <= UDC_RST_UPPER;
            st_ff.lower  <= UDC_RST_LOWER;
            st_ff.exc    <= UDC_EX_NONE;
            st_ff.fNull  <= 1'b1;
            st_ff.fLo    <= 1'b1;
            st_ff.awRdy  <= 1'b1;
            st_ff.wRdy   <= 1'b1;
            st_ff.arRdy  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Retained storage, one byte per lane, kept over reset.
    // It is only written while running, so the zero count left by a
    // reset cannot overwrite the saved value before the run start.
    always_ff @(posedge ref_clk) begin
        if (retain && runMode && st_ff.rPrev) begin
            nvOk <= 1'b1;
        end
    end
    for (genvar g = 0; g < UDC_NV_BYTES; g++) begin : gNv
        // Follows the count while retentive and running, else holds.
        always_ff @(posedge ref_clk) begin
            if (retain && runMode && st_ff.rPrev) begin
                nvMem[g] <= st_ff.count[8*g +: 8];
            end
        end
    end

    // Outputs straight from the state flops.
    assign actualCountValid = st_ff.rPrev;
    assign actualCount      = st_ff.count;
    assign atOrAboveUpper   = st_ff.fUp;
    assign atOrBelowLower   = st_ff.fLo;
    assign countIsNull      = st_ff.fNull;
    assign rangeCarry       = st_ff.carry;
    assign s_axi_awready    = st_ff.awRdy;
    assign s_axi_wready     = st_ff.wRdy;
    assign s_axi_bvalid     = st_ff.bVal;
    assign s_axi_bresp      = st_ff.bResp;
    assign s_axi_arready    = st_ff.arRdy;
    assign s_axi_rvalid     = st_ff.rVal;
    assign s_axi_rdata      = st_ff.rData;
    assign s_axi_rresp      = st_ff.rResp;

    // ==================================================================
    // Assertions.
    // ==================================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Gates the enable, step, clear, load and steady-level checks to running cycles other than the run start.
    logic plain;  // Ordinary running cycle.
    assign plain = runMode & st_ff.rPrev;

    a_enable_gate: assert property (
        plain && st_ff.cfg[UDC_CFG_ENREQ_BIT] && !enableIn
        |=> $stable(st_ff.count))
        else $error("Count moved while enable was low.");
    a_count_up: assert property (
        plain && active && rise && !clearInput && !loadInitial
        && !countDown && st_ff.count != 32'h7FFF_FFFF
        |=> st_ff.count == $past(st_ff.count) + 32'h0000_0001)
        else $error("Upward step was not one.");
    a_count_down: assert property (
        plain && active && rise && !clearInput && !loadInitial
        && countDown && st_ff.count != 32'h8000_0000
        |=> st_ff.count == $past(st_ff.count) - 32'h0000_0001)
        else $error("Downward step was not one.");
    a_upper_flag: assert property (
        st_ff.exc == UDC_EX_NONE |->
        st_ff.fUp == ($signed(st_ff.count) >= $signed(st_ff.upper)))
        else $error("Upper flag disagrees with count.");
    a_lower_flag: assert property (
        st_ff.exc == UDC_EX_NONE |->
        st_ff.fLo == ($signed(st_ff.count) <= $signed(st_ff.lower)))
        else $error("Lower flag disagrees with count.");
    a_null_flag: assert property (
        st_ff.count == 32'h0000_0000 && !st_ff.lower[31]
        && st_ff.exc == UDC_EX_NONE |-> st_ff.fNull && st_ff.fLo)
        else $error("Zero count without null and lower flags.");
    a_clear_wins: assert property (
        plain && active && clearInput
        |=> st_ff.count == 32'h0000_0000 && st_ff.fNull)
        else $error("Clear did not zero the count.");
    a_load_init: assert property (
        plain && active && !clearInput && loadInitial && !st_ff.lPrev
        |=> st_ff.count == $past(st_ff.init))
        else $error("Load did not copy the initial value.");
    a_carry_hold: assert property (
        st_ff.carry |-> st_ff.count == $past(st_ff.count)
        ##1 !st_ff.carry)
        else $error("Carry not a held one-cycle pulse.");
    a_steady_level: assert property (
        plain && !rise && !clearInput && !(loadInitial && !st_ff.lPrev)
        |=> $stable(st_ff.count))
        else $error("Count moved without a rising edge.");

    c_reach_upper: cover property (!st_ff.fUp ##1 st_ff.fUp);
    c_carry:       cover property (st_ff.carry);
    c_load:        cover property (plain && loadInitial && !st_ff.lPrev);
    c_bus_write:   cover property (st_ff.bVal && s_axi_bready);
endmodule // udc_counter

// ---- verif/udc_scan_model.sv ----
// Program scan model: drives trains of count pulses into the counter.
// Assumes ref_clk and the active-low asynchronous resetn of the block.
`timescale 1ns/1ns
module udc_scan_model (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       go,
    input  wire logic [7:0] pulses,
    input  wire logic [3:0] width,
    output logic            countPulse,
    output logic            busy
);
    logic [7:0] left; // Pulses still to send.
    logic [3:0] ph;   // Cycles spent in the current level.
    // =================================================================
    // Pulse train: each level is held for width cycles, low first.
    // =================================================================
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            countPulse <= 1'b0;
            left       <= 8'h00;
            ph         <= 4'h0;
        end else if (go && left == 8'h00) begin
            left <= pulses;
            ph   <= 4'h0;
        end else if (left != 8'h00) begin
            // The bench only asks for widths above two cycles.
            if (ph == width - 4'h1) begin
                ph         <= 4'h0;
                countPulse <= ~countPulse;
                if (countPulse) begin
                    left <= left - 8'h01;
                end
            end else begin
                ph <= ph + 4'h1;
            end
        end
    end
    assign busy = (left != 8'h00);
endmodule // udc_scan_model

// ---- verif/up_down_threshold_counter_tb_top.sv ----
// Self-checking bench of the up/down threshold counter.
// Assumes udc_pkg, udc_counter and udc_scan_model are compiled first.
`timescale 1ns/1ns
module up_down_threshold_counter_tb_top;
    import udc_pkg::*;
    logic        ref_clk, resetn, countPulse, countDown, loadInitial;
    logic        clearInput, enableIn, runMode, actualCountValid;
    logic [31:0] actualCount;
    logic        atOrAboveUpper, atOrBelowLower, countIsNull, rangeCarry;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        go, busy;
    logic [7:0]  nPulse;
    logic [3:0]  width;
    logic [31:0] rng, upLim, loLim, cur, d;
    int          numErrors, nCompared, cycles, carryCnt;
    udc_counter DUT (.ref_clk, .resetn, .countPulse, .countDown,
        .loadInitial, .clearInput, .enableIn, .runMode, .actualCountValid,
        .actualCount, .atOrAboveUpper, .atOrBelowLower, .countIsNull,
        .rangeCarry, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp);
    udc_scan_model scan (.ref_clk, .resetn, .go, .pulses(nPulse), .width,
        .countPulse, .busy);
    // =================================================================
    // Clock, cycle limit and carry pulse counting.
    // =================================================================
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (rangeCarry === 1'b1) carryCnt++;
        if (cycles == 30000) begin
            numErrors++;
            finish_test();
        end
    end
    // =================================================================
    // Helpers: random source, expectations, comparisons, bus cycles.
    // =================================================================
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // Expected flags {null, lower, upper} for a count and the limits.
    function automatic logic [31:0] expSt(input logic [31:0] c);
        return {29'h0, c == 32'h0, $signed(c) <= $signed(loLim),
                $signed(c) >= $signed(upLim)};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axiWr(input logic [7:0] a, input logic [31:0] v,
                         output logic [1:0] rs);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic axiRd(input logic [7:0] a, output logic [31:0] v,
                         output logic [1:0] rs);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Compares count, flags and the count register with the expectation.
    task automatic chkState(input logic [31:0] e);
        check("count", actualCount, e);
        check("flags", {29'h0, countIsNull, atOrBelowLower, atOrAboveUpper},
              expSt(e));
        axiRd(UDC_OFF_COUNT, d, r);
        check("count register", d, e);
    endtask
    // Sends n count pulses of random width and lets the result settle.
    task automatic train(input int n);
        nPulse <= 8'(n);
        width  <= 4'(3 + rnd() % 4);
        go     <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        for (int t = 0; t < 4000; t++) begin
            @(posedge ref_clk);
            if (!busy) break;
        end
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic strobe(input logic clr, input logic ld);
        clearInput  <= clr;
        loadInitial <= ld;
        repeat (3) @(posedge ref_clk);
        clearInput  <= 1'b0;
        loadInitial <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // =================================================================
    // Main sequence.
    // =================================================================
    initial begin
        {countDown, loadInitial, clearInput, enableIn, runMode, go} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        nPulse = 8'h00;
        width = 4'h3;
        rng = 32'h6F71;
        {numErrors, nCompared, cycles, carryCnt} = '0;
        upLim = UDC_RST_UPPER;
        loLim = UDC_RST_LOWER;
        resetn = 1'b0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            axiRd(8'(4 * i), d, r);
            check("reset value", d, i == 2 ? UDC_RST_UPPER : 32'h0);
        end
        axiRd(8'h40, d, r);
        check("unmapped read", {d[29:0], r}, {30'h0, UDC_RESP_SLV});
        axiWr(8'h40, 32'h1, r);
        check("unmapped write", {30'h0, r}, {30'h0, UDC_RESP_SLV});
        axiWr(UDC_OFF_COUNT, 32'h55, r);
        chkState(32'h0);
        $display("test reset done");
        runMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        upLim = 32'(5 + rnd() % 8);
        axiWr(UDC_OFF_UPPER, upLim, r);
        train(1);
        chkState(32'h1);
        train(int'(upLim) - 2);
        chkState(upLim - 32'h1);
        train(1);
        chkState(upLim);
        $display("test up count done");
        cur = (rnd() & 32'hFF) - 32'h80;
        axiWr(UDC_OFF_INIT, cur, r);
        strobe(1'b0, 1'b1);
        chkState(cur);
        loLim = cur - 32'h3;
        axiWr(UDC_OFF_LOWER, loLim, r);
        countDown <= 1'b1;
        train(2);
        chkState(cur - 32'h2);
        train(1);
        chkState(cur - 32'h3);
        strobe(1'b1, 1'b1);
        chkState(32'h0);
        $display("test load and down done");
        axiWr(UDC_OFF_CONFIG, 32'h1, r);
        train(3);
        chkState(32'h0);
        enableIn <= 1'b1;
        train(2);
        chkState(32'hFFFF_FFFE);
        axiWr(UDC_OFF_CONFIG, 32'h0, r);
        enableIn <= 1'b0;
        train(1);
        chkState(32'hFFFF_FFFD);
        $display("test enable done");
        for (int dir = 0; dir < 2; dir++) begin
            cur = dir == 1 ? 32'h8000_0000 : 32'h7FFF_FFFF;
            countDown <= dir[0];
            axiWr(UDC_OFF_INIT, cur, r);
            strobe(1'b0, 1'b1);
            carryCnt = 0;
            train(2);
            check("carry", 32'(carryCnt), 32'h2);
            chkState(cur);
        end
        $display("test range done");
        countDown <= 1'b0;
        axiWr(UDC_OFF_CONFIG, 32'h0000_0100, r);
        cur = rnd() & 32'hFFFF;
        axiWr(UDC_OFF_INIT, cur, r);
        strobe(1'b0, 1'b1);
        runMode <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check("valid", {31'h0, actualCountValid}, 32'h0);
        chkState(cur);
        // Power loss while stopped: registers reset, storage kept.
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        upLim = UDC_RST_UPPER;
        loLim = UDC_RST_LOWER;
        chkState(32'h0);
        axiWr(UDC_OFF_CONFIG, 32'h0000_0100, r);
        runMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("valid", {31'h0, actualCountValid}, 32'h1);
        chkState(cur);
        axiWr(UDC_OFF_CONFIG, 32'h0, r);
        runMode <= 1'b0;
        repeat (3) @(posedge ref_clk);
        runMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chkState(32'h0);
        $display("test retention done");
        finish_test();
    end
endmodule // up_down_threshold_counter_tb_top
